// ### bench/dpll_channel_status_readback_test.sv
// Self-checking bench for the loop channel status readback.
`timescale 1ns/100ps
`default_nettype none
module dpll_channel_status_readback_test
	import slew_status_pkg::*;
;
	logic               sys_clk = 1'b0;
	logic               rstn = 1'b0;
	logic [ADDR_W-1:0]  reg_addr = '0;
	logic [DATA_W-1:0]  reg_wdata = '0;
	logic               reg_wr = 1'b0;
	logic               reg_rd = 1'b0;
	logic [DATA_W-1:0]  reg_rdata;
	logic [LEVEL_W-1:0] level = '0;
	logic [3:0]         slew = '0;
	logic [3:0]         fail = '0;
	logic               irq;
	logic [7:0]         d;
	logic [15:0]        addrs [6] = '{16'h320B, 16'h320C, 16'h320D, 16'h320E, 16'h3211, 16'h3212};
	int                 error_cnt = 0;
	int                 cmp_count = 0;
	int                 cyc = 0;
	int                 m_level = 0, m_slew = 0, m_fail = 0, m_stat = 0, m_mask = 0, nerr;

	always #2.5 sys_clk = ~sys_clk;

	dpll_channel_status_readback u_dpll_channel_status_readback (
		.sys_clk(sys_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.freq_lock_detector_level(level),
		.divider_a_primary_slewing(slew[0]), .divider_a_complement_slewing(slew[1]),
		.divider_b_primary_slewing(slew[2]), .divider_b_complement_slewing(slew[3]),
		.divider_a_primary_fail(fail[0]), .divider_a_complement_fail(fail[1]),
		.divider_b_primary_fail(fail[2]), .divider_b_complement_fail(fail[3]),
		.irq(irq)
	);

	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check

	task automatic wr(input logic [15:0] a, input logic [7:0] v);
		@(posedge sys_clk);
		reg_addr  <= a;
		reg_wdata <= v;
		reg_wr    <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask : wr

	// Read data are sampled just after the edge that registers them, inside their only cycle.
	task automatic rd(input logic [15:0] a, output logic [7:0] v);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
	endtask : rd

	task automatic tally_and_finish;
		$display("Comparisons %0d, errors %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : tally_and_finish

	// The ceiling is about fifteen times the expected run length.
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 4000) begin
			error_cnt++;
			tally_and_finish();
		end
	end

	initial begin
		void'($urandom(32'h9F20));
		repeat (10) @(posedge sys_clk);
		rstn <= 1'b1;
		foreach (addrs[i]) begin
			rd(addrs[i], d);
			check(d, 8'h00);
		end
		wr(IRQ_MASK_OFS, 8'h03);
		m_mask = 3;
		rd(IRQ_MASK_OFS, d);
		check(d, 8'h03);
		for (int i = 0; i < 12; i++) begin
			@(posedge sys_clk);
			level <= 12'($urandom);
			slew  <= 4'($urandom);
			fail  <= 4'($urandom);
			repeat (4) @(posedge sys_clk);
			rd(FREQ_LOCK_LEVEL_LOW_OFS, d);
			check(d, 8'(m_level));
			if (i == 6) begin
				wr(IRQ_MASK_OFS, 8'h00);
				m_mask = 0;
			end
			wr(UPDATE_CMD_OFS, 8'h01);
			nerr = int'(fail) & ~m_fail;
			m_stat = m_stat | 1 | ((nerr != 0) ? 2 : 0);
			m_level = int'(level);
			m_slew = int'(slew);
			m_fail = int'(fail);
			rd(FREQ_LOCK_LEVEL_LOW_OFS, d);
			check(d, 8'(m_level));
			rd(FREQ_LOCK_LEVEL_HIGH_OFS, d);
			check(d, 8'(m_level >> 8));
			rd(SLEW_ACTIVE_OFS, d);
			check(d, 8'(m_slew));
			rd(SLEW_ERROR_OFS, d);
			check(d, 8'(m_fail));
			check({7'h00, irq}, {7'h00, (m_stat & m_mask) != 0});
			rd(IRQ_STATUS_OFS, d);
			check(d, 8'(m_stat));
			m_stat = 0;
			check({7'h00, irq}, 8'h00);
		end
		rd(16'h320F, d);
		check(d, 8'h00);
		wr(FREQ_LOCK_LEVEL_LOW_OFS, 8'hFF);
		rd(FREQ_LOCK_LEVEL_LOW_OFS, d);
		check(d, 8'(m_level));
		tally_and_finish();
	end
endmodule : dpll_channel_status_readback_test
`default_nettype wire

// ### core/dpll_channel_status_readback.sv
// Snapshot status readback of the second loop channel with event interrupt.
//
// Functional notes
// R01 - Frequency lock detector level is 12 bits: low byte, then high nibble next.
// R02 - Software must issue update strobe right before reading for fresh values.
// R03 - Four read-only flags, one per divider, high while phase slew runs.
// R04 - Four read-only error flags, high when requested phase adjustment cannot finish.
// R05 - Flag order from bit 0: A primary, A complement, B primary, B complement.
// R06 - Flag fields occupy bits 3..0; all reserved upper bits read zero.
//
// Implementation choice: the strobed register port.
`timescale 1ns/100ps
`default_nettype none
module dpll_channel_status_readback
	import slew_status_pkg::*;
(
	input  wire logic              sys_clk,
	input  wire logic              rstn,
	input  wire logic [ADDR_W-1:0] reg_addr,
	input  wire logic [DATA_W-1:0] reg_wdata,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	output var  logic [DATA_W-1:0] reg_rdata,
	input  wire logic [LEVEL_W-1:0] freq_lock_detector_level,
	input  wire logic              divider_a_primary_slewing,
	input  wire logic              divider_a_complement_slewing,
	input  wire logic              divider_b_primary_slewing,
	input  wire logic              divider_b_complement_slewing,
	input  wire logic              divider_a_primary_fail,
	input  wire logic              divider_a_complement_fail,
	input  wire logic              divider_b_primary_fail,
	input  wire logic              divider_b_complement_fail,
	output var  logic              irq
);

	logic [LEVEL_W-1:0]  level_synced;
	logic [NUM_DIV-1:0]  active_raw;
	logic [NUM_DIV-1:0]  error_raw;
	logic [NUM_DIV-1:0]  active_sync;
	logic [NUM_DIV-1:0]  error_sync;

	logic [LEVEL_W-1:0]  level_reg;
	logic [NUM_DIV-1:0]  active_reg;
	logic [NUM_DIV-1:0]  error_reg;
	logic [IRQ_W-1:0]    irq_status_reg;
	logic [IRQ_W-1:0]    irq_status_next;
	logic [IRQ_W-1:0]    irq_mask_reg;
	logic [DATA_W-1:0]   rdata_next;

	wire                 update_hit;
	wire                 mask_wr_hit;
	wire                 status_rd_hit;
	wire [IRQ_W-1:0]     irq_events;
	wire [NUM_DIV-1:0]   new_errors;

	// Divider flags are packed so that the bit index is the divider position.
	assign active_raw[DIV_A_PRIMARY_BIT]    = divider_a_primary_slewing;    // R05
	assign active_raw[DIV_A_COMPLEMENT_BIT] = divider_a_complement_slewing; // R05
	assign active_raw[DIV_B_PRIMARY_BIT]    = divider_b_primary_slewing;    // R05
	assign active_raw[DIV_B_COMPLEMENT_BIT] = divider_b_complement_slewing; // R05
	assign error_raw[DIV_A_PRIMARY_BIT]     = divider_a_primary_fail;       // R05
	assign error_raw[DIV_A_COMPLEMENT_BIT]  = divider_a_complement_fail;    // R05
	assign error_raw[DIV_B_PRIMARY_BIT]     = divider_b_primary_fail;       // R05
	assign error_raw[DIV_B_COMPLEMENT_BIT]  = divider_b_complement_fail;    // R05

	level_sync #(
		.WIDTH(LEVEL_W + 2 * NUM_DIV)
	) u_sync (
		.sys_clk (sys_clk),
		.rstn    (rstn),
		.async_in({freq_lock_detector_level, active_raw, error_raw}),
		.sync_out({level_synced, active_sync, error_sync})
	);

	assign update_hit    = reg_wr && (reg_addr == UPDATE_CMD_OFS) && reg_wdata[UPDATE_CMD_BIT];
	assign mask_wr_hit   = reg_wr && (reg_addr == IRQ_MASK_OFS);
	assign status_rd_hit = reg_rd && (reg_addr == IRQ_STATUS_OFS);

	// An error event is a divider failing that was clear in the last snapshot.
	assign new_errors = error_sync & ~error_reg;

	assign irq_events[IRQ_SNAPSHOT_BIT] = update_hit;
	assign irq_events[IRQ_ERROR_BIT]    = update_hit && (|new_errors);

	// Set wins over the read that clears, so an event in the read cycle survives.
	assign irq_status_next = (status_rd_hit ? '0 : irq_status_reg) | irq_events;

	// Snapshot registers only move on an update command, so reads are coherent.
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			level_reg  <= LEVEL_RESET;
			active_reg <= FLAGS_RESET;
			error_reg  <= FLAGS_RESET;
		end else if (update_hit) begin
			level_reg  <= level_synced; // R01
			active_reg <= active_sync; // R03
			error_reg  <= error_sync;  // R04
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			irq_status_reg <= IRQ_MASK_RESET;
			irq_mask_reg   <= IRQ_MASK_RESET;
		end else begin
			irq_status_reg <= irq_status_next;
			if (mask_wr_hit) begin
				irq_mask_reg <= reg_wdata[IRQ_W-1:0];
			end
		end
	end

	always_comb begin
		rdata_next = ZERO_BYTE;
		case (reg_addr)
			FREQ_LOCK_LEVEL_LOW_OFS:  rdata_next = level_reg[7:0];                     // R01
			FREQ_LOCK_LEVEL_HIGH_OFS: rdata_next = {4'h0, level_reg[LEVEL_W-1:8]};     // R06
			SLEW_ACTIVE_OFS:          rdata_next = {4'h0, active_reg};                 // R03
			SLEW_ERROR_OFS:           rdata_next = {4'h0, error_reg};                  // R04
			IRQ_STATUS_OFS:           rdata_next = {6'h00, irq_status_reg};
			IRQ_MASK_OFS:             rdata_next = {6'h00, irq_mask_reg};
			default:                  rdata_next = ZERO_BYTE;
		endcase
	end

	// Read data is held only in the cycle after the strobe and is zero otherwise.
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			reg_rdata <= ZERO_BYTE;
		end else begin
			reg_rdata <= reg_rd ? rdata_next : ZERO_BYTE;
		end
	end

	assign irq = |(irq_status_reg & irq_mask_reg);

	// Bus rules keep the write and read strobes apart, so no check below expects both.
	// Checks that reach back three cycles trust that no update follows reset that closely.

	sequence update_cmd_s;
		update_hit;
	endsequence

	sequence rd_low_s;
		reg_rd && (reg_addr == FREQ_LOCK_LEVEL_LOW_OFS);
	endsequence

	sequence rd_active_s;
		reg_rd && (reg_addr == SLEW_ACTIVE_OFS);
	endsequence

	sequence rd_status_s;
		reg_rd && !reg_wr && (reg_addr == IRQ_STATUS_OFS);
	endsequence

	snapshot_level_a: assert property (@(posedge sys_clk) disable iff (!rstn) // R01
		update_cmd_s |=> (level_reg == $past(level_synced)))
		else $error("Level snapshot did not capture synchronised level.");

	read_low_a: assert property (@(posedge sys_clk) disable iff (!rstn) // R01
		rd_low_s |=> (reg_rdata == level_reg[7:0]))
		else $error("Low level byte read returned wrong data.");

	read_high_a: assert property (@(posedge sys_clk) disable iff (!rstn) // R06
		(reg_rd && reg_addr == FREQ_LOCK_LEVEL_HIGH_OFS) |=>
		(reg_rdata[7:4] == 4'h0) && (reg_rdata[3:0] == level_reg[11:8]))
		else $error("High level nibble read wrong or reserved bits set.");

	snapshot_active_a: assert property (@(posedge sys_clk) disable iff (!rstn) // R03
		rd_active_s |=> (reg_rdata == {4'h0, $past(active_reg)}))
		else $error("Slew active flags not returned from snapshot.");

	snapshot_error_a: assert property (@(posedge sys_clk) disable iff (!rstn) // R04
		update_cmd_s |=> (error_reg == $past(error_sync)))
		else $error("Slew error flags not captured on update.");

	flag_order_a: assert property (@(posedge sys_clk) disable iff (!rstn) // R05
		update_cmd_s |=> (active_reg == {$past(divider_b_complement_slewing, 3),
		$past(divider_b_primary_slewing, 3), $past(divider_a_complement_slewing, 3),
		$past(divider_a_primary_slewing, 3)}))
		else $error("Divider flag order is wrong.");

	error_order_a: assert property (@(posedge sys_clk) disable iff (!rstn) // R05
		update_cmd_s |=> (error_reg == {$past(divider_b_complement_fail, 3),
		$past(divider_b_primary_fail, 3), $past(divider_a_complement_fail, 3),
		$past(divider_a_primary_fail, 3)}))
		else $error("Divider error flag order is wrong.");

	hold_snapshot_a: assert property (@(posedge sys_clk) disable iff (!rstn) // R02
		!update_hit |=> $stable(level_reg) && $stable(active_reg) && $stable(error_reg))
		else $error("Snapshot changed without update command.");

	flag_reserved_a: assert property (@(posedge sys_clk) disable iff (!rstn) // R06
		(reg_rd && (reg_addr == SLEW_ACTIVE_OFS || reg_addr == SLEW_ERROR_OFS)) |=>
		(reg_rdata[7:4] == 4'h0))
		else $error("Reserved flag bits read nonzero.");

	irq_level_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		update_cmd_s ##1 (irq_mask_reg[IRQ_SNAPSHOT_BIT] && !status_rd_hit) |-> irq)
		else $error("Interrupt not raised after unmasked snapshot event.");

	status_read_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		rd_status_s |=> (reg_rdata == {6'h00, $past(irq_status_reg)}))
		else $error("Interrupt status read returned wrong data.");

	status_clear_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		rd_status_s |=> (irq_status_reg == IRQ_MASK_RESET))
		else $error("Interrupt status not cleared by its read.");

	error_event_a: assert property (@(posedge sys_clk) disable iff (!rstn) // R04
		update_cmd_s |=> !(|(error_reg & ~$past(error_reg)))
		|| irq_status_reg[IRQ_ERROR_BIT])
		else $error("New divider error did not set its status bit.");

	mask_write_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		(reg_wr && reg_addr == IRQ_MASK_OFS) |=> (irq_mask_reg == $past(reg_wdata[IRQ_W-1:0])))
		else $error("Interrupt mask write not taken.");

	irq_off_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		(irq_mask_reg == IRQ_MASK_RESET) |-> !irq)
		else $error("Interrupt raised while fully masked.");

	reset_quiet_a: assert property (@(posedge sys_clk)
		!rstn |=> (reg_rdata == ZERO_BYTE) && !irq)
		else $error("Read data or interrupt not quiet after reset.");

endmodule : dpll_channel_status_readback
`default_nettype wire

// ### core/level_sync.sv
// Two flip-flop synchroniser for a bundle of independent status levels.
`timescale 1ns/100ps
`default_nettype none
module level_sync
	import slew_status_pkg::*;
#(
	parameter int unsigned WIDTH = 1
) (
	input  wire logic             sys_clk,
	input  wire logic             rstn,
	input  wire logic [WIDTH-1:0] async_in,
	output var  logic [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_reg;

	// Each bit is synchronised alone; the lock level crosses as a slowly moving value
	// and a snapshot taken mid-change may hold a mix of old and new bits.
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			meta_reg <= '0;
			sync_out <= '0;
		end else begin
			meta_reg <= async_in;
			sync_out <= meta_reg;
		end
	end

endmodule : level_sync
`default_nettype wire

// ### shared/slew_status_pkg.sv
// Register map, field layout and timing constants of the loop channel status readback.
package slew_status_pkg;

	localparam int unsigned ADDR_W                  = 16;
	localparam int unsigned DATA_W                  = 8;
	localparam int unsigned LEVEL_W                 = 12;
	localparam int unsigned NUM_DIV                 = 4;

	localparam logic [15:0] FREQ_LOCK_LEVEL_LOW_OFS = 16'h320B;
	localparam logic [15:0] FREQ_LOCK_LEVEL_HIGH_OFS = 16'h320C;
	localparam logic [15:0] SLEW_ACTIVE_OFS         = 16'h320D;
	localparam logic [15:0] SLEW_ERROR_OFS          = 16'h320E;
	localparam logic [15:0] UPDATE_CMD_OFS          = 16'h3210;
	localparam logic [15:0] IRQ_STATUS_OFS          = 16'h3211;
	localparam logic [15:0] IRQ_MASK_OFS            = 16'h3212;

	localparam int unsigned UPDATE_CMD_BIT          = 0;

	localparam int unsigned DIV_A_PRIMARY_BIT       = 0;
	localparam int unsigned DIV_A_COMPLEMENT_BIT    = 1;
	localparam int unsigned DIV_B_PRIMARY_BIT       = 2;
	localparam int unsigned DIV_B_COMPLEMENT_BIT    = 3;

	localparam int unsigned IRQ_SNAPSHOT_BIT        = 0;
	localparam int unsigned IRQ_ERROR_BIT           = 1;
	localparam int unsigned IRQ_W                   = 2;

	localparam logic [7:0]  ZERO_BYTE               = 8'h00;
	localparam logic [1:0]  IRQ_MASK_RESET          = 2'h0;
	localparam logic [11:0] LEVEL_RESET             = 12'h000;
	localparam logic [3:0]  FLAGS_RESET             = 4'h0;

	localparam int unsigned SYNC_STAGES             = 2;

endpackage : slew_status_pkg
